// ===== scr_pkg.sv
// Constants, types and decode helpers for the serializer control registers
package scr_pkg;

	// Timing
	localparam int CLK_PERIOD_NS      = 10;
	localparam int RESET_PULSE_NS     = 100;
	localparam int RESET_PULSE_CYCLES = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RST_CNT_W          = $clog2(RESET_PULSE_CYCLES + 1);
	localparam logic [RST_CNT_W-1:0] RST_CNT_LOAD = RST_CNT_W'(RESET_PULSE_CYCLES);
	localparam logic [RST_CNT_W-1:0] RST_CNT_ZERO = '0;
	localparam logic [1:0] STRAP_SETTLE = 2'h3;

	// Register offsets
	localparam logic [7:0] OFS_ADDR   = 8'h00;
	localparam logic [7:0] OFS_RESET  = 8'h01;
	localparam logic [7:0] OFS_GENCFG = 8'h03;

	// Field positions
	localparam int ADDR_SRC_BIT    = 0;
	localparam int RST_SLEEP_BIT   = 7;
	localparam int RST_VIDEO_BIT   = 4;
	localparam int RST_FULL_BIT    = 1;
	localparam int RST_KEEP_BIT    = 0;
	localparam int CFG_CRC_BIT     = 7;
	localparam int CFG_AUTOACK_BIT = 5;
	localparam int CFG_FILTER_BIT  = 4;
	localparam int CFG_PASS_BIT    = 3;
	localparam int CFG_OSC_BIT     = 1;

	// Reset values and writable masks
	localparam logic       ADDR_SRC_RESET = 1'h0;
	localparam logic [7:0] GENCFG_RESET   = 8'hD2;
	localparam logic [7:0] GENCFG_WMASK   = 8'hBA;
	localparam logic [7:0] BYTE_ZERO      = 8'h00;

	// Serial bus byte framing
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] LAST_BIT  = 4'h7;
	localparam logic [3:0] BIT_ZERO  = 4'h0;

	// Strap level limits (8-bit level) and the addresses they select
	localparam int STRAP_CODES = 8;
	localparam logic [7:0] STRAP_LIMIT [STRAP_CODES-1] = '{8'h1B, 8'h44, 8'h61, 8'h7F,
		8'h9C, 8'hBA, 8'hE4};
	localparam logic [6:0] STRAP_ADDR [STRAP_CODES] = '{7'h0C, 7'h0E, 7'h10, 7'h12,
		7'h14, 7'h16, 7'h18, 7'h1A};

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RX   = 3'b001,
		ST_ACK  = 3'b010,
		ST_TX   = 3'b011,
		ST_MACK = 3'b100
	} scr_state_type;

	typedef enum logic [1:0] {
		PH_ADDR = 2'b00,
		PH_OFS  = 2'b01,
		PH_DATA = 2'b10
	} scr_phase_type;

	typedef struct packed {
		logic crc_check_en;
		logic glitch_filter_en;
		logic port0_auto_ack;
		logic port1_auto_ack;
		logic port0_pass_through;
		logic port1_pass_through;
		logic use_internal_osc;
	} scr_cfg_type;

	function automatic logic [6:0] scr_strap_decode(input logic [7:0] level);
		int idx;
		idx = 0;
		for (int i = 0; i < STRAP_CODES - 1; i++) begin
			if (level >= STRAP_LIMIT[i]) begin
				idx = i + 1;
			end
		end
		return STRAP_ADDR[idx];
	endfunction

endpackage

// ===== scr_registers.sv
// Serial-bus slave and control register bank of the serializer
// Notes on behaviour
// (R1) Address register bits 7:1 hold own bus address, loaded from the strap.
// (R2) Address bit 0 picks strapped address (0) or register address (1).
// (R3) Reset register bit 7 set: power down while no control link is seen.
// (R4) Sleep-on-link-loss bit loads from the first mode strap at power-up.
// (R5) Writing 1 to reset bit 4 resets video input block; self-clearing.
// (R6) Writing 1 to reset bit 1 resets all logic and registers; self-clearing.
// (R7) Writing 1 to reset bit 0 resets logic but keeps registers; self-clearing.
// (R8) Config bit 7 enables back-channel CRC check; register resets to 0xD2.
// (R9) Config bit 5 acknowledges remote writes at once; default off.
// (R10) With auto-acknowledge, remote not-acknowledges never reach the local master.
// (R11) Second-port select moves auto-acknowledge and pass-through to port one.
// (R12) Config bit 4 enables two-clock glitch filter on sync and valid inputs.
// (R13) Config bit 3 forwards alias-matching transfers to the remote side; default off.
// (R14) Config bit 1 switches to internal oscillator when video clock absent.
// (R15) Strap level decodes into one of eight default bus addresses.
// (R16) Self-clearing reset bits read 0 once their reset has completed.
// (R17) Reserved bits ignore writes and read their default values.
`timescale 1ns/10ps
`default_nettype none

module scr_registers
	import scr_pkg::*;
(
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        srst,
	// Serial control bus pins
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe_n,
	// Strap pins
	input  wire logic [7:0]  address_strap_pin,
	input  wire logic        first_mode_strap_pin,
	// Device status inputs
	input  wire logic        link_detected,
	input  wire logic        video_clock_present,
	input  wire logic        second_port_select,
	// Control outputs
	output scr_cfg_type      cfg,
	output logic             power_down,
	output logic             video_input_reset,
	output logic             logic_reset
);

	// Synchronisers: scl, sda, link, video clock, mode strap, address strap
	localparam int SYNC_W = 13;
	logic [SYNC_W-1:0] sync_a;
	logic [SYNC_W-1:0] sync_b;
	logic              scl_q;
	logic              sda_q;
	logic              scl_s;
	logic              sda_s;
	logic              link_s;
	logic              vclk_s;
	logic              mode_strap_s;
	logic [7:0]        addr_strap_s;

	always_ff @(posedge mclk) begin
		sync_a <= {address_strap_pin, first_mode_strap_pin, video_clock_present,
			link_detected, sda_in, scl_in};
		sync_b <= sync_a;
		scl_q  <= scl_s;
		sda_q  <= sda_s;
	end

	assign scl_s        = sync_b[0];
	assign sda_s        = sync_b[1];
	assign link_s       = sync_b[2];
	assign vclk_s       = sync_b[3];
	assign mode_strap_s = sync_b[4];
	assign addr_strap_s = sync_b[12:5];

	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;

	assign scl_rise   = scl_s & ~scl_q;
	assign scl_fall   = ~scl_s & scl_q;
	assign start_seen = scl_s & scl_q & sda_q & ~sda_s;
	assign stop_seen  = scl_s & scl_q & ~sda_q & sda_s;

	// Open drain: only ever pulls low
	assign sda_out = 1'b0;

	// Register bank state
	logic [6:0]           addr_reg;
	logic                 addr_src;
	logic                 sleep_en;
	logic [7:0]           gencfg;
	logic [RST_CNT_W-1:0] video_cnt;
	logic [RST_CNT_W-1:0] full_cnt;
	logic [RST_CNT_W-1:0] keep_cnt;
	logic [1:0]           strap_wait;
	logic                 strap_done;
	logic [6:0]           strap_addr;
	logic                 strap_sleep;

	logic [6:0] own_addr;
	logic       video_busy;
	logic       full_busy;
	logic       keep_busy;

	assign video_busy = video_cnt != RST_CNT_ZERO;
	assign full_busy  = full_cnt != RST_CNT_ZERO;
	assign keep_busy  = keep_cnt != RST_CNT_ZERO;
	// (R2) address source select
	assign own_addr = addr_src ? addr_reg : strap_addr;

	function automatic logic [7:0] read_byte(input logic [7:0] ofs);
		logic [7:0] v;
		v = BYTE_ZERO;
		unique case (ofs)
			OFS_ADDR: begin
				v = {addr_reg, addr_src};
			end
			OFS_RESET: begin
				// (R16) busy bits drop when done
				v[RST_SLEEP_BIT] = sleep_en;
				v[RST_VIDEO_BIT] = video_busy;
				v[RST_FULL_BIT]  = full_busy;
				v[RST_KEEP_BIT]  = keep_busy;
			end
			OFS_GENCFG: begin
				// (R17) reserved bits read default
				v = (gencfg & GENCFG_WMASK) | (GENCFG_RESET & ~GENCFG_WMASK);
			end
			default: begin
				v = BYTE_ZERO;
			end
		endcase
		return v;
	endfunction

	// Bus engine state
	scr_state_type state;
	scr_state_type next_state;
	scr_phase_type phase;
	scr_phase_type next_phase;
	logic [3:0]    bitcnt;
	logic [3:0]    next_bitcnt;
	logic [7:0]    shreg;
	logic [7:0]    next_shreg;
	logic [7:0]    ptr;
	logic [7:0]    next_ptr;
	logic          is_read;
	logic          next_is_read;
	logic          next_sda_oe_n;
	logic          wr_en;
	logic [7:0]    rd_now;

	// Process form so register changes behind the pointer are seen
	always_comb begin
		rd_now = read_byte(ptr);
	end

	always_comb begin
		next_state    = state;
		next_phase    = phase;
		next_bitcnt   = bitcnt;
		next_shreg    = shreg;
		next_ptr      = ptr;
		next_is_read  = is_read;
		next_sda_oe_n = sda_oe_n;
		wr_en         = 1'b0;
		if (stop_seen) begin
			next_state    = ST_IDLE;
			next_sda_oe_n = 1'b1;
		end else if (start_seen) begin
			next_state    = ST_RX;
			next_phase    = PH_ADDR;
			next_bitcnt   = BIT_ZERO;
			next_sda_oe_n = 1'b1;
		end else begin
			unique case (state)
				ST_IDLE: begin
					next_sda_oe_n = 1'b1;
				end
				ST_RX: begin
					if (scl_rise) begin
						next_shreg  = {shreg[6:0], sda_s};
						next_bitcnt = bitcnt + 4'h1;
					end else if (scl_fall && bitcnt == BYTE_BITS) begin
						next_bitcnt = BIT_ZERO;
						next_state  = ST_ACK;
						unique case (phase)
							PH_ADDR: begin
								if (shreg[7:1] == own_addr) begin
									next_sda_oe_n = 1'b0;
									next_is_read  = shreg[0];
								end else begin
									next_state = ST_IDLE;
								end
							end
							PH_OFS: begin
								next_ptr      = shreg;
								next_sda_oe_n = 1'b0;
							end
							default: begin
								wr_en         = 1'b1;
								next_sda_oe_n = 1'b0;
							end
						endcase
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						if (phase == PH_ADDR && is_read) begin
							next_state    = ST_TX;
							next_phase    = PH_DATA;
							next_shreg    = rd_now;
							next_sda_oe_n = rd_now[7];
						end else begin
							next_state    = ST_RX;
							next_sda_oe_n = 1'b1;
							if (phase == PH_ADDR) begin
								next_phase = PH_OFS;
							end else begin
								next_phase = PH_DATA;
								if (phase == PH_DATA) begin
									next_ptr = ptr + 8'h01;
								end
							end
						end
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (bitcnt == LAST_BIT) begin
							next_state    = ST_MACK;
							next_sda_oe_n = 1'b1;
							next_bitcnt   = BIT_ZERO;
							next_ptr      = ptr + 8'h01;
						end else begin
							next_shreg    = {shreg[6:0], 1'b0};
							next_bitcnt   = bitcnt + 4'h1;
							next_sda_oe_n = shreg[6];
						end
					end
				end
				ST_MACK: begin
					if (scl_rise && sda_s) begin
						next_state = ST_IDLE;
					end else if (scl_fall) begin
						next_state    = ST_TX;
						next_shreg    = rd_now;
						next_sda_oe_n = rd_now[7];
					end
				end
				default: begin
					next_state    = ST_IDLE;
					next_sda_oe_n = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			state    <= ST_IDLE;
			phase    <= PH_ADDR;
			bitcnt   <= BIT_ZERO;
			shreg    <= BYTE_ZERO;
			ptr      <= BYTE_ZERO;
			is_read  <= 1'b0;
			sda_oe_n <= 1'b1;
		end else begin
			state    <= next_state;
			phase    <= next_phase;
			bitcnt   <= next_bitcnt;
			shreg    <= next_shreg;
			ptr      <= next_ptr;
			is_read  <= next_is_read;
			sda_oe_n <= next_sda_oe_n;
		end
	end

	// Register bank next values
	logic [6:0]           next_addr_reg;
	logic                 next_addr_src;
	logic                 next_sleep_en;
	logic [7:0]           next_gencfg;
	logic [RST_CNT_W-1:0] next_video_cnt;
	logic [RST_CNT_W-1:0] next_full_cnt;
	logic [RST_CNT_W-1:0] next_keep_cnt;
	logic [1:0]           next_strap_wait;
	logic                 next_strap_done;
	logic [6:0]           next_strap_addr;
	logic                 next_strap_sleep;
	scr_cfg_type          next_cfg;
	logic                 next_power_down;
	logic                 next_video_input_reset;
	logic                 next_logic_reset;

	always_comb begin
		next_addr_reg    = addr_reg;
		next_addr_src    = addr_src;
		next_sleep_en    = sleep_en;
		next_gencfg      = gencfg;
		next_strap_wait  = strap_wait;
		next_strap_done  = strap_done;
		next_strap_addr  = strap_addr;
		next_strap_sleep = strap_sleep;
		// (R16) counters run down to zero
		next_video_cnt = video_busy ? video_cnt - RST_CNT_W'(1) : video_cnt;
		next_full_cnt  = full_busy ? full_cnt - RST_CNT_W'(1) : full_cnt;
		next_keep_cnt  = keep_busy ? keep_cnt - RST_CNT_W'(1) : keep_cnt;
		if (!strap_done) begin
			if (strap_wait == STRAP_SETTLE) begin
				// (R15) strap level decode
				next_strap_addr  = scr_strap_decode(addr_strap_s);
				next_strap_sleep = mode_strap_s;
				next_strap_done  = 1'b1;
				// (R1) address from strap
				next_addr_reg    = scr_strap_decode(addr_strap_s);
				// (R4) sleep from mode strap
				next_sleep_en    = mode_strap_s;
			end else begin
				next_strap_wait = strap_wait + 2'h1;
			end
		end else if (full_busy) begin
			// (R6) registers held at defaults
			next_addr_reg = strap_addr;
			next_addr_src = ADDR_SRC_RESET;
			next_sleep_en = strap_sleep;
			next_gencfg   = GENCFG_RESET;
		end else if (wr_en) begin
			unique case (ptr)
				OFS_ADDR: begin
					next_addr_reg = shreg[7:1];
					next_addr_src = shreg[ADDR_SRC_BIT];
				end
				OFS_RESET: begin
					next_sleep_en = shreg[RST_SLEEP_BIT];
					// (R5) video block reset
					if (shreg[RST_VIDEO_BIT]) begin
						next_video_cnt = RST_CNT_LOAD;
					end
					// (R6) full reset trigger
					if (shreg[RST_FULL_BIT]) begin
						next_full_cnt = RST_CNT_LOAD;
					end
					// (R7) reset keeping registers
					if (shreg[RST_KEEP_BIT]) begin
						next_keep_cnt = RST_CNT_LOAD;
					end
				end
				OFS_GENCFG: begin
					// (R17) only writable bits change
					next_gencfg = (shreg & GENCFG_WMASK) | (GENCFG_RESET & ~GENCFG_WMASK);
				end
				default: begin
					next_gencfg = gencfg;
				end
			endcase
		end
		// (R8) CRC checker enable
		next_cfg.crc_check_en       = gencfg[CFG_CRC_BIT];
		// (R12) glitch filter enable
		next_cfg.glitch_filter_en   = gencfg[CFG_FILTER_BIT];
		// (R9) (R10) (R11) auto-acknowledge per port
		next_cfg.port0_auto_ack     = gencfg[CFG_AUTOACK_BIT] & ~second_port_select;
		next_cfg.port1_auto_ack     = gencfg[CFG_AUTOACK_BIT] & second_port_select;
		// (R13) (R11) pass-through per port
		next_cfg.port0_pass_through = gencfg[CFG_PASS_BIT] & ~second_port_select;
		next_cfg.port1_pass_through = gencfg[CFG_PASS_BIT] & second_port_select;
		// (R14) oscillator fallback
		next_cfg.use_internal_osc   = gencfg[CFG_OSC_BIT] & ~vclk_s;
		// (R3) sleep on link loss
		next_power_down        = sleep_en & ~link_s;
		next_video_input_reset = video_busy | full_busy | keep_busy;
		next_logic_reset       = full_busy | keep_busy;
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			addr_reg          <= STRAP_ADDR[0];
			addr_src          <= ADDR_SRC_RESET;
			sleep_en          <= 1'b0;
			gencfg            <= GENCFG_RESET;
			video_cnt         <= RST_CNT_ZERO;
			full_cnt          <= RST_CNT_ZERO;
			keep_cnt          <= RST_CNT_ZERO;
			strap_wait        <= 2'h0;
			strap_done        <= 1'b0;
			strap_addr        <= STRAP_ADDR[0];
			strap_sleep       <= 1'b0;
			cfg               <= '0;
			power_down        <= 1'b0;
			video_input_reset <= 1'b0;
			logic_reset       <= 1'b0;
		end else begin
			addr_reg          <= next_addr_reg;
			addr_src          <= next_addr_src;
			sleep_en          <= next_sleep_en;
			gencfg            <= next_gencfg;
			video_cnt         <= next_video_cnt;
			full_cnt          <= next_full_cnt;
			keep_cnt          <= next_keep_cnt;
			strap_wait        <= next_strap_wait;
			strap_done        <= next_strap_done;
			strap_addr        <= next_strap_addr;
			strap_sleep       <= next_strap_sleep;
			cfg               <= next_cfg;
			power_down        <= next_power_down;
			video_input_reset <= next_video_input_reset;
			logic_reset       <= next_logic_reset;
		end
	end

endmodule

`default_nettype wire

// ===== scr_registers_asserts.sv
// Checker on the control register bank ports
`timescale 1ns/10ps
`default_nettype none

module scr_registers_asserts
	import scr_pkg::*;
(
	// Clock and reset
	input wire logic        mclk,
	input wire logic        srst,
	// Bus pins
	input wire logic        scl_in,
	input wire logic        sda_in,
	input wire logic        sda_out,
	input wire logic        sda_oe_n,
	// Straps and status
	input wire logic [7:0]  address_strap_pin,
	input wire logic        first_mode_strap_pin,
	input wire logic        link_detected,
	input wire logic        video_clock_present,
	input wire logic        second_port_select,
	// Control outputs
	input wire scr_cfg_type cfg,
	input wire logic        power_down,
	input wire logic        video_input_reset,
	input wire logic        logic_reset
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (srst);

	sequence s_released;
		$fell(srst);
	endsequence
	// Ten cycles high, then low
	sequence s_ten(sig);
		sig[*8] ##1 sig[*2] ##1 !sig;
	endsequence

	a_reset_outputs: assert property (
		s_released |-> sda_oe_n && !power_down && !logic_reset && !video_input_reset)
		else $error("outputs active after reset");
	a_cfg_defaults: assert property (
		s_released |-> !(|cfg) ##1 (cfg.crc_check_en && cfg.glitch_filter_en
		&& !cfg.port0_auto_ack && !cfg.port0_pass_through))
		else $error("configuration defaults wrong");
	a_link_awake: assert property (
		link_detected[*5] |-> !power_down)
		else $error("power down with link present");
	a_osc_clk_present: assert property (
		video_clock_present[*5] |-> !cfg.use_internal_osc)
		else $error("oscillator switch with clock present");
	a_port_one_sel: assert property (
		second_port_select[*3] |-> !cfg.port0_auto_ack && !cfg.port0_pass_through)
		else $error("port zero enabled while port one selected");
	a_port_zero_sel: assert property (
		(!second_port_select)[*3] |-> !cfg.port1_auto_ack && !cfg.port1_pass_through)
		else $error("port one enabled while port zero selected");
	a_video_pulse: assert property (
		$rose(video_input_reset) |-> s_ten(video_input_reset))
		else $error("video reset pulse length wrong");
	a_logic_pulse: assert property (
		$rose(logic_reset) |-> s_ten(logic_reset))
		else $error("logic reset pulse length wrong");
	a_logic_covers_video: assert property (
		logic_reset |-> video_input_reset)
		else $error("logic reset without video reset");
endmodule

bind scr_registers scr_registers_asserts scr_registers_asserts_i (
	.mclk(mclk), .srst(srst), .scl_in(scl_in), .sda_in(sda_in),
	.sda_out(sda_out), .sda_oe_n(sda_oe_n), .address_strap_pin(address_strap_pin),
	.first_mode_strap_pin(first_mode_strap_pin), .link_detected(link_detected),
	.video_clock_present(video_clock_present), .second_port_select(second_port_select),
	.cfg(cfg), .power_down(power_down), .video_input_reset(video_input_reset),
	.logic_reset(logic_reset)
);

`default_nettype wire

// ===== scr_host_model.sv
// Bus host controller model for the serial control bus
`timescale 1ns/10ps
`default_nettype none

module scr_host_model (
	// Clock
	input  wire logic mclk,
	// Device data line drive
	input  wire logic sda_oe_n,
	input  wire logic sda_out,
	// Resolved bus lines
	output logic      scl,
	output logic      sda_line
);
	logic sda_drv = 1'h1;

	initial scl = 1'h1;
	// Open drain line with pull-up
	assign sda_line = sda_drv & (sda_oe_n | sda_out);

	task automatic hp();
		repeat (5) @(posedge mclk);
	endtask

	task automatic start();
		sda_drv <= 1'h1;
		hp();
		scl <= 1'h1;
		hp();
		sda_drv <= 1'h0;
		hp();
		scl <= 1'h0;
		hp();
	endtask

	task automatic stop();
		sda_drv <= 1'h0;
		hp();
		scl <= 1'h1;
		hp();
		sda_drv <= 1'h1;
		hp();
	endtask

	task automatic bit_io(input logic b, output logic r);
		sda_drv <= b;
		hp();
		scl <= 1'h1;
		hp();
		r = sda_line;
		scl <= 1'h0;
		hp();
	endtask

	task automatic put(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'h1, r);
		ack = ~r;
	endtask

	task automatic get(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'h1, d[i]);
		bit_io(last, r);
	endtask
endmodule

`default_nettype wire

// ===== tb_serializer_control_registers.sv
// Self-checking bench for the serializer control registers
`timescale 1ns/10ps
`default_nettype none

module tb_serializer_control_registers
	import scr_pkg::*;
;
	localparam logic [6:0] own = 7'h12;
	logic        mclk;
	logic        srst;
	logic        scl;
	logic        sda;
	logic        sda_out;
	logic        sda_oe_n;
	logic [7:0]  address_strap_pin;
	logic        first_mode_strap_pin;
	logic        link_detected;
	logic        video_clock_present;
	logic        second_port_select;
	scr_cfg_type cfg;
	logic        power_down;
	logic        video_input_reset;
	logic        logic_reset;
	int          err_count = 0;
	int          compares = 0;
	int          vir_n = 0;
	int          lr_n = 0;

	scr_registers scr_registers_i (.mclk(mclk), .srst(srst), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n), .address_strap_pin(address_strap_pin),
		.first_mode_strap_pin(first_mode_strap_pin), .link_detected(link_detected),
		.video_clock_present(video_clock_present), .second_port_select(second_port_select),
		.cfg(cfg), .power_down(power_down), .video_input_reset(video_input_reset),
		.logic_reset(logic_reset));
	scr_host_model scr_host_model_i (.mclk(mclk), .sda_oe_n(sda_oe_n), .sda_out(sda_out),
		.scl(scl), .sda_line(sda));

	initial begin
		mclk = 1'h0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		if (video_input_reset) vir_n <= vir_n + 1;
		if (logic_reset) lr_n <= lr_n + 1;
	end

	task automatic finish_test();
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] dat,
		output logic ok);
		logic a0, a1, a2;
		scr_host_model_i.start();
		scr_host_model_i.put({dev, 1'h0}, a0);
		scr_host_model_i.put(ofs, a1);
		scr_host_model_i.put(dat, a2);
		scr_host_model_i.stop();
		ok = a0 & a1 & a2;
	endtask

	task automatic rd(input logic [6:0] dev, input logic [7:0] ofs, output logic [7:0] dat);
		logic a;
		scr_host_model_i.start();
		scr_host_model_i.put({dev, 1'h0}, a);
		scr_host_model_i.put(ofs, a);
		scr_host_model_i.start();
		scr_host_model_i.put({dev, 1'h1}, a);
		scr_host_model_i.get(1'h1, dat);
		scr_host_model_i.stop();
	endtask

	task automatic chkrd(input logic [7:0] ofs, input logic [7:0] exp);
		logic [7:0] d;
		rd(own, ofs, d);
		chk(d, exp);
	endtask

	task automatic pulse(input logic [7:0] v, input logic [7:0] nv, input logic [7:0] nl);
		int v0, l0;
		logic ok;
		v0 = vir_n;
		l0 = lr_n;
		wr(own, OFS_RESET, v, ok);
		repeat (20) @(posedge mclk);
		chk(8'(vir_n - v0), nv);
		chk(8'(lr_n - l0), nl);
	endtask

	task automatic t_defaults();
		chkrd(OFS_ADDR, 8'h24);
		chkrd(OFS_RESET, 8'h80);
		chkrd(OFS_GENCFG, GENCFG_RESET);
		chkrd(8'h02, BYTE_ZERO);
		chk({1'h0, cfg}, 8'h60);
		link_detected <= 1'h0;
		repeat (10) @(posedge mclk);
		chk({7'h00, power_down}, 8'h01);
		link_detected <= 1'h1;
		repeat (10) @(posedge mclk);
		chk({7'h00, power_down}, 8'h00);
		$display("defaults test done");
	endtask

	task automatic t_address();
		logic ok;
		logic [7:0] d;
		wr(own, OFS_ADDR, 8'h51, ok);
		chk({7'h00, ok}, 8'h01);
		rd(own, OFS_ADDR, d);
		chk(d, 8'hFF);
		rd(7'h28, OFS_ADDR, d);
		chk(d, 8'h51);
		wr(7'h28, OFS_ADDR, 8'h24, ok);
		chkrd(OFS_ADDR, 8'h24);
		$display("address test done");
	endtask

	task automatic t_config();
		logic ok;
		video_clock_present <= 1'h0;
		wr(own, OFS_GENCFG, 8'hFF, ok);
		chkrd(OFS_GENCFG, 8'hFA);
		chk({1'h0, cfg}, 8'h75);
		video_clock_present <= 1'h1;
		repeat (6) @(posedge mclk);
		chk({1'h0, cfg}, 8'h74);
		video_clock_present <= 1'h0;
		second_port_select <= 1'h1;
		repeat (6) @(posedge mclk);
		chk({1'h0, cfg}, 8'h6B);
		second_port_select <= 1'h0;
		wr(own, OFS_GENCFG, 8'h00, ok);
		chkrd(OFS_GENCFG, 8'h40);
		chk({1'h0, cfg}, 8'h00);
		wr(own, 8'h02, 8'h5A, ok);
		chkrd(8'h02, BYTE_ZERO);
		video_clock_present <= 1'h1;
		$display("config test done");
	endtask

	task automatic t_resets();
		logic ok;
		pulse(8'h90, 8'(RESET_PULSE_CYCLES), 8'h00);
		chkrd(OFS_RESET, 8'h80);
		pulse(8'h81, 8'(RESET_PULSE_CYCLES), 8'(RESET_PULSE_CYCLES));
		chkrd(OFS_GENCFG, 8'h40);
		wr(own, OFS_ADDR, 8'h25, ok);
		pulse(8'h82, 8'(RESET_PULSE_CYCLES), 8'(RESET_PULSE_CYCLES));
		chkrd(OFS_GENCFG, GENCFG_RESET);
		chkrd(OFS_ADDR, 8'h24);
		chkrd(OFS_RESET, 8'h80);
		$display("reset test done");
	endtask

	task automatic t_burst();
		logic a;
		logic [7:0] d0, d1, d2, d3;
		scr_host_model_i.start();
		scr_host_model_i.put({own, 1'h0}, a);
		scr_host_model_i.put(OFS_ADDR, a);
		scr_host_model_i.start();
		scr_host_model_i.put({own, 1'h1}, a);
		chk({7'h00, a}, 8'h01);
		scr_host_model_i.get(1'h0, d0);
		scr_host_model_i.get(1'h0, d1);
		scr_host_model_i.get(1'h0, d2);
		scr_host_model_i.get(1'h1, d3);
		scr_host_model_i.stop();
		chk(d0, 8'h24);
		chk(d1, 8'h80);
		chk(d2, BYTE_ZERO);
		chk(d3, GENCFG_RESET);
		$display("burst test done");
	endtask

	initial begin
		repeat (60000) @(posedge mclk);
		err_count++;
		finish_test();
	end

	initial begin
		srst = 1'h1;
		address_strap_pin = 8'h70;
		first_mode_strap_pin = 1'h1;
		link_detected = 1'h1;
		video_clock_present = 1'h1;
		second_port_select = 1'h0;
		repeat (20) @(posedge mclk);
		srst <= 1'h0;
		repeat (20) @(posedge mclk);
		t_defaults();
		t_address();
		t_config();
		t_resets();
		t_burst();
		finish_test();
	end
endmodule

`default_nettype wire
